// ===== verilog/plcir_regs.sv
// link-control, power-class and interrupt register bank
`timescale 1ns/1ps
`include "plcir_defs.svh"
module plcir_regs
  import plcir_pkg::*;
(
  // clock and hardware reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // pins
  input wire logic link_power_status_in,
  input wire logic cable_power_in,
  input wire logic [2:0] power_class_pins,
  // events from the link-layer machinery
  input wire logic bus_reset_in,
  input wire logic bus_idle,
  input wire logic arb_config_timeout,
  input wire logic legacy_nodes_present,
  input wire logic state_timeout,
  input wire logic [`PLCIR_NPORTS-1:0] port_status_change,
  input wire logic [`PLCIR_NPORTS-1:0] port_resume_start,
  // outputs
  output logic link_on_out,
  output logic link_if_operational,
  output logic selfid_link_active,
  output logic selfid_contender,
  output logic [2:0] selfid_power_class,
  output logic short_reset_active,
  output logic bus_reset_req,
  output logic irq
);
  // ****************************************
  // synchronised pins
  // ****************************************
  logic lps_s; // link power status
  logic cps_s; // cable power
  logic [2:0] pc_s; // power class pins
  logic cps_d; // delayed cable power

  plcir_sync #(.W(5)) u_sync (
    .clk(clk),
    .d({link_power_status_in, cable_power_in, power_class_pins}),
    .q({lps_s, cps_s, pc_s})
  );

  // ****************************************
  // registers
  // ****************************************
  logic link_active_control; // self-ID link control
  logic contender_flag; // self-ID contender
  logic [2:0] node_power_class; // self-ID power class
  logic resume_irq_enable; // resume / watchdog enable
  logic short_reset_request; // short reset pending
  logic config_timeout_flag; // sticky flags
  logic cable_power_flag;
  logic state_timeout_flag;
  logic port_event_flag;
  logic [`PLCIR_NPORTS-1:0] port_irq_enable; // per-port enables
  logic [3:0] irq_status; // interrupt status, read clears
  logic [3:0] irq_mask; // interrupt mask
  logic pc_loaded; // power class taken after reset
  logic sr_done; // short reset sequence finished
  logic any_bus_reset; // any bus reset this cycle

  // helper: write to an address
  function automatic logic wr_at(input logic [3:0] a);
    return wr && (addr == a);
  endfunction

  logic wr_ctrl;
  logic wr_irq;
  logic cps_fall; // cable power high to low
  logic set_cto;
  logic set_sto;
  logic set_pev;
  logic timeout_any; // any watchdog-class flag
  logic [3:0] ev; // events for irq status

  assign wr_ctrl = wr_at(`PLCIR_ADDR_CTRL);
  assign wr_irq = wr_at(`PLCIR_ADDR_IRQ);
  assign cps_fall = cps_d && !cps_s;
  // legacy-only loop detect
  assign set_cto = arb_config_timeout && legacy_nodes_present; // RQ10 RQ12
  assign set_sto = state_timeout; // RQ14
  assign timeout_any = config_timeout_flag || cable_power_flag || state_timeout_flag;
  // interface state depends only on power input
  assign link_if_operational = lps_s; // RQ3
  assign any_bus_reset = bus_reset_in || sr_done || state_timeout;
  assign bus_reset_req = state_timeout; // RQ14
  // port event causes
  assign set_pev = |(port_status_change & port_irq_enable) // RQ15
    || (resume_irq_enable && |port_resume_start) // RQ7
    || (resume_irq_enable && !lps_s && (set_cto || set_sto || cps_fall)); // RQ7

  // cable power edge history
  always_ff @(posedge clk) begin
    if (reset) begin
      cps_d <= 1'b1;
    end else begin
      cps_d <= cps_s;
    end
  end

  // link control and contender; bus reset leaves them
  always_ff @(posedge clk) begin
    if (reset) begin
      link_active_control <= 1'b1; // RQ2
      contender_flag <= 1'b0; // RQ4
      resume_irq_enable <= 1'b0; // RQ7
    end else if (wr_ctrl) begin
      link_active_control <= wdata[`PLCIR_B_LINK_ACTIVE_CONTROL];
      contender_flag <= wdata[`PLCIR_B_CONT]; // RQ4
    end else if (wr_irq) begin
      resume_irq_enable <= wdata[`PLCIR_B_RESEN];
    end
  end

  // power class from pins after reset release
  always_ff @(posedge clk) begin
    if (reset) begin
      pc_loaded <= 1'b0;
      node_power_class <= 3'h0;
    end else if (!pc_loaded) begin
      pc_loaded <= 1'b1;
      node_power_class <= pc_s; // RQ6
    end else if (wr_ctrl) begin
      node_power_class <= wdata[`PLCIR_B_PWR_HI:`PLCIR_B_PWR_LO];
    end
  end

  // short reset request, cleared by any bus reset
  always_ff @(posedge clk) begin
    if (reset) begin
      short_reset_request <= 1'b0;
    end else if (any_bus_reset) begin
      short_reset_request <= 1'b0; // RQ8
    end else if (wr_irq && wdata[`PLCIR_B_SHORT]) begin
      short_reset_request <= 1'b1; // RQ8
    end
  end

  plcir_short_reset u_short (
    .clk(clk),
    .reset(reset),
    .request(short_reset_request),
    .bus_idle(bus_idle),
    .active(short_reset_active),
    .done(sr_done)
  );

  // sticky flags: set wins, write one clears, zero keeps
  always_ff @(posedge clk) begin
    if (reset) begin
      config_timeout_flag <= 1'b0; // RQ10
      cable_power_flag <= 1'b1; // RQ13
      state_timeout_flag <= 1'b0; // RQ14
      port_event_flag <= 1'b0; // RQ15
    end else begin
      config_timeout_flag <= set_cto
        || (config_timeout_flag && !(wr_irq && wdata[`PLCIR_B_CTO])); // RQ16
      cable_power_flag <= cps_fall
        || (cable_power_flag && !(wr_irq && wdata[`PLCIR_B_CPS])); // RQ13 RQ16
      state_timeout_flag <= set_sto
        || (state_timeout_flag && !(wr_irq && wdata[`PLCIR_B_STO])); // RQ16
      port_event_flag <= set_pev
        || (port_event_flag && !(wr_irq && wdata[`PLCIR_B_PEV])); // RQ16
    end
  end

  // port enables and interrupt mask
  always_ff @(posedge clk) begin
    if (reset) begin
      port_irq_enable <= '0;
      irq_mask <= 4'h0;
    end else if (wr_at(`PLCIR_ADDR_PORTEN)) begin
      port_irq_enable <= wdata[`PLCIR_NPORTS-1:0];
    end else if (wr_at(`PLCIR_ADDR_MASK)) begin
      irq_mask <= wdata[3:0];
    end
  end

  // interrupt status: events set, read clears, set wins
  assign ev = {set_cto, cps_fall, set_sto, set_pev};
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status <= 4'h0;
    end else if (rd && addr == `PLCIR_ADDR_STAT) begin
      irq_status <= ev;
    end else begin
      irq_status <= irq_status | ev;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // link-on when a timeout flag is set with enable, link inactive
  always_ff @(posedge clk) begin
    if (reset) begin
      link_on_out <= 1'b0;
    end else begin
      link_on_out <= resume_irq_enable && timeout_any && !lps_s; // RQ11
    end
  end

  // self-ID fields
  always_ff @(posedge clk) begin
    if (reset) begin
      selfid_link_active <= 1'b0;
      selfid_contender <= 1'b0;
      selfid_power_class <= 3'h0;
    end else begin
      selfid_link_active <= link_active_control && lps_s; // RQ1
      selfid_contender <= contender_flag; // RQ4
      selfid_power_class <= node_power_class; // RQ6
    end
  end

  // ****************************************
  // read port, data one cycle after strobe
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `PLCIR_ADDR_CTRL: begin
          rdata <= {link_active_control, contender_flag, `PLCIR_JITTER_VAL, // RQ5
                    node_power_class};
        end
        `PLCIR_ADDR_IRQ: begin
          rdata <= {resume_irq_enable, short_reset_request, config_timeout_flag,
                    cable_power_flag, state_timeout_flag, port_event_flag, 2'h0};
        end
        `PLCIR_ADDR_PORTEN: begin
          rdata <= {5'h00, port_irq_enable};
        end
        `PLCIR_ADDR_STAT: begin
          rdata <= {4'h0, irq_status};
        end
        `PLCIR_ADDR_MASK: begin
          rdata <= {4'h0, irq_mask};
        end
        default: begin
          rdata <= 8'h00;
        end
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

// ===== inc/plcir_defs.svh
// constants for the link-control and interrupt register block
// Operation
// (RQ1) self-ID link flag is control AND power
// (RQ2) link control set by hardware reset only; a write to the control register also loads it
// (RQ3) link interface state follows power input only
// (RQ4) contender cleared at reset, set by write
// (RQ5) repeater jitter field reads zero
// (RQ6) power class loads pins at hardware reset
// (RQ7) resume enable feeds port event flag
// (RQ8) short reset request, cleared by bus reset
// (RQ9) software should use only short resets
// (RQ10) config timeout flag, write one clears
// (RQ11) timeout flags with enable raise link-on
// (RQ12) config timeout only with legacy nodes present
// (RQ13) cable power flag on falling edge, resets one
// (RQ14) state timeout flag also causes bus reset
// (RQ15) port change with enable sets port event
// (RQ16) writing zero leaves flags unchanged
`ifndef PLCIR_DEFS_SVH
`define PLCIR_DEFS_SVH
// ****************************************
// register offsets
// ****************************************
`define PLCIR_ADDR_CTRL 4'h4
`define PLCIR_ADDR_IRQ 4'h5
`define PLCIR_ADDR_PORTEN 4'h8
`define PLCIR_ADDR_STAT 4'h9
`define PLCIR_ADDR_MASK 4'hA
// ****************************************
// field positions, numbered as data bit indices, bit 7 = data[7] = msb
// ****************************************
`define PLCIR_B_LINK_ACTIVE_CONTROL 7
`define PLCIR_B_CONT 6
`define PLCIR_B_JIT_HI 5
`define PLCIR_B_JIT_LO 3
`define PLCIR_B_PWR_HI 2
`define PLCIR_B_PWR_LO 0
`define PLCIR_B_RESEN 7
`define PLCIR_B_SHORT 6
`define PLCIR_B_CTO 5
`define PLCIR_B_CPS 4
`define PLCIR_B_STO 3
`define PLCIR_B_PEV 2
// ****************************************
// reset values and timing
// ****************************************
`define PLCIR_JITTER_VAL 3'h0
`define PLCIR_CLK_NS 40
`define PLCIR_SHORT_RST_NS 1300
`define PLCIR_SHORT_RST_CYC ((`PLCIR_SHORT_RST_NS + `PLCIR_CLK_NS - 1) / `PLCIR_CLK_NS)
`define PLCIR_NPORTS 3
`endif

// ===== inc/plcir_pkg.sv
// types for the link-control and interrupt register block
package plcir_pkg;
  typedef enum logic [1:0] {PLCIR_IDLE, PLCIR_WAIT, PLCIR_RESET} plcir_rst_e;
  typedef logic [7:0] plcir_byte_t;
endpackage

// ===== verilog/plcir_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module plcir_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk,
  // pin side
  input wire logic [W-1:0] d,
  // clock side
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // first stage, read only by q

  // two stages
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule

// ===== verilog/plcir_short_reset.sv
// short arbitrated bus reset sequencer
`timescale 1ns/1ps
`include "plcir_defs.svh"
module plcir_short_reset
  import plcir_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic request,
  input wire logic bus_idle,
  // outputs
  output logic active,
  output logic done
);
  localparam logic [7:0] LEN = 8'(`PLCIR_SHORT_RST_CYC);
  plcir_rst_e state; // sequencer state
  logic [7:0] count; // remaining cycles

  // wait for an opportunity, then drive reset for 1.3 us
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= PLCIR_IDLE;
      count <= 8'h00;
    end else begin
      case (state)
        PLCIR_IDLE: begin
          if (request) begin
            state <= PLCIR_WAIT;
          end
        end
        PLCIR_WAIT: begin
          // next opportunity; a bus reset that dropped the request cancels it
          if (!request) begin
            state <= PLCIR_IDLE;
          end else if (bus_idle) begin
            state <= PLCIR_RESET;
            count <= LEN;
          end
        end
        PLCIR_RESET: begin
          if (count == 8'h01) begin
            state <= PLCIR_IDLE;
          end
          count <= count - 8'h01;
        end
        default: begin
          state <= PLCIR_IDLE;
        end
      endcase
    end
  end

  assign active = (state == PLCIR_RESET);
  assign done = (state == PLCIR_RESET) && (count == 8'h01);
endmodule

// ===== verif/plcir_link_model.sv
// link controller model: register master and link power pin
`timescale 1ns/1ps
module plcir_link_model (
  // clock
  input wire logic clk,
  // register port
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata,
  // link power pin
  output logic lpwr
);
  // idle bus at time zero
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    lpwr = 1'b0;
  end
  // one-cycle write, data line then shows a changed value
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // one-cycle read, data taken in the following cycle only
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule

// ===== verif/plcir_regs_sva.sv
// port assertions for the register bank
`timescale 1ns/1ps
module plcir_regs_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // events and outputs
  input wire logic bus_idle,
  input wire logic state_timeout,
  input wire logic link_if_operational,
  input wire logic link_on_out,
  input wire logic selfid_link_active,
  input wire logic short_reset_active,
  input wire logic bus_reset_req,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] run_len; // cycles of the current short reset
  // count the length of each short reset
  always_ff @(posedge clk) begin
    if (reset || !short_reset_active) begin
      run_len <= 8'h00;
    end else begin
      run_len <= run_len + 8'h01;
    end
  end
  property p_rd_zero; !$past(rd) |-> rdata == 8'h00; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
  property p_jit; rd && addr == 4'h4 |=> rdata[5:3] == 3'h0; endproperty
  a_jit: assert property (p_jit) else $error("jitter not zero");
  property p_slink; selfid_link_active |-> $past(link_if_operational); endproperty
  a_slink: assert property (p_slink) else $error("link flag without power");
  property p_lon; link_on_out |-> !$past(link_if_operational); endproperty
  a_lon: assert property (p_lon) else $error("link-on while active");
  property p_breq; state_timeout |-> bus_reset_req; endproperty
  a_breq: assert property (p_breq) else $error("timeout without bus reset");
  property p_mask; wr && addr == 4'hA && wdata == 8'h00 |=> !irq; endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt seen");
  property p_slen; $fell(short_reset_active) |-> run_len == 8'h21; endproperty
  a_slen: assert property (p_slen) else $error("short reset length");
  property p_sgo; $rose(short_reset_active) |-> $past(bus_idle); endproperty
  a_sgo: assert property (p_sgo) else $error("short reset while busy");
  c_short: cover property ($rose(short_reset_active));
  c_irq: cover property ($rose(irq));
  c_lon: cover property ($rose(link_on_out));
endmodule
bind plcir_regs plcir_regs_sva u_sva (.clk(clk), .reset(reset), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus_idle(bus_idle),
  .state_timeout(state_timeout), .link_if_operational(link_if_operational),
  .link_on_out(link_on_out), .selfid_link_active(selfid_link_active),
  .short_reset_active(short_reset_active), .bus_reset_req(bus_reset_req), .irq(irq));

// ===== verif/test_phy_link_control_interrupt_regs.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
module test_phy_link_control_interrupt_regs;
  // ****************************************
  // signals
  // ****************************************
  logic clk, reset, cab_pwr, idle, legacy, wr, rd, lpwr, lon, lop, sla, scon, sra, irq;
  logic [2:0] pclass, spc;
  logic [3:0] addr;
  logic [8:0] ev; // {resume, change, bus reset, state to, config to}
  logic [7:0] wdata, rdata, got, m4, m5;
  int bad_count, n_checks, seed, k;
  plcir_link_model u_link (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .lpwr(lpwr));
  plcir_regs u_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .link_power_status_in(lpwr), .cable_power_in(cab_pwr),
    .power_class_pins(pclass), .bus_reset_in(ev[2]), .bus_idle(idle),
    .arb_config_timeout(ev[0]), .legacy_nodes_present(legacy), .state_timeout(ev[1]),
    .port_status_change(ev[5:3]), .port_resume_start(ev[8:6]), .link_on_out(lon),
    .link_if_operational(lop), .selfid_link_active(sla), .selfid_contender(scon),
    .selfid_power_class(spc), .short_reset_active(sra), .bus_reset_req(), .irq(irq));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle event pulse
  task automatic pulse(input logic [8:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 9'h000;
    #1;
  endtask
  // read a register through the link model and compare with the expected value
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    u_link.get(a, got);
    chk(got, exp);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard
  initial begin
    tick(100000);
    bad_count++;
    report_and_stop();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'h740136c4;
    pclass = 3'($random(seed));
    {reset, cab_pwr, idle, legacy, ev} = {4'b1100, 9'h000};
    tick(20);
    reset <= 1'b0;
    tick(4);
    m4 = {5'b10000, pclass};
    m5 = 8'h10;
    rchk(4'h4, m4);
    chk(spc, pclass);
    rchk(4'h5, m5);
    u_link.put(4'h5, 8'h00);
    rchk(4'h5, m5);
    u_link.put(4'h5, 8'h10);
    m5 = 8'h00;
    rchk(4'h5, m5);
    k = $random(seed);
    m4 = {5'b11000, k[2:0]};
    u_link.put(4'h4, m4 | 8'h38);
    rchk(4'h4, m4);
    pulse(9'h004);
    rchk(4'h4, m4);
    chk(scon, 1'b1);
    u_link.lpwr <= 1'b1;
    tick(5);
    chk(sla, 1'b1);
    u_link.put(4'h4, m4 & 8'h7F);
    tick(3);
    chk(sla, 1'b0);
    chk(lop, 1'b1);
    pulse(9'h001);
    rchk(4'h5, m5);
    legacy <= 1'b1;
    pulse(9'h001);
    rchk(4'h5, 8'h20);
    pulse(9'h002);
    rchk(4'h5, 8'h28);
    cab_pwr <= 1'b0;
    tick(5);
    rchk(4'h5, 8'h38);
    u_link.put(4'h8, 8'h07);
    pulse(9'h008 << ({$random(seed)} % 3));
    rchk(4'h5, 8'h3C);
    u_link.put(4'h5, 8'h24);
    rchk(4'h5, 8'h18);
    u_link.lpwr <= 1'b0;
    u_link.put(4'h5, 8'h80);
    tick(4);
    chk(lon, 1'b1);
    u_link.put(4'h5, 8'h98);
    tick(3);
    chk(lon, 1'b0);
    pulse(9'h040 << ({$random(seed)} % 3));
    rchk(4'h5, 8'h84);
    u_link.put(4'h5, 8'h84);
    pulse(9'h002);
    rchk(4'h5, 8'h8C);
    u_link.put(4'h5, 8'h8C);
    idle <= 1'b1;
    u_link.put(4'h5, 8'hC0);
    for (k = 0; k < 50 && !sra; k++) tick(1);
    if (k == 50) begin
      bad_count++;
      report_and_stop();
    end
    for (k = 0; k < 100 && sra; k++) tick(1);
    chk(k[7:0], 8'h21);
    idle <= 1'b0;
    rchk(4'h5, 8'h80);
    u_link.put(4'h5, 8'hC0);
    pulse(9'h004);
    rchk(4'h5, 8'h80);
    idle <= 1'b1;
    tick(5);
    chk(sra, 1'b0);
    idle <= 1'b0;
    u_link.get(4'h9, got);
    u_link.put(4'hA, 8'hFF);
    pulse(9'h002);
    tick(2);
    chk(irq, 1'b1);
    u_link.get(4'h9, got);
    chk(irq, 1'b0);
    u_link.put(4'hA, 8'h00);
    pulse(9'h002);
    tick(2);
    chk(irq, 1'b0);
    rchk(4'hF, 8'h00);
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(4);
    rchk(4'h4, {5'b10000, pclass});
    rchk(4'h5, 8'h10);
    report_and_stop();
  end
endmodule
